// >>> hdl/cpc_top.sv
/*
 Code protection, identification and programming-mode gate.
 Assumes programmer writes arrive as single-cycle strobes synchronous to
 clk_sys_i, and the high-voltage detect is already a clean level.
*/
// Summary of operation
// RL1: Per-block guard blocks foreign table reads.
// RL2: Eleven-bit part number over two ID registers.
// RL3: Five-bit revision shares lower ID register.
// RL4: Low-voltage enable bit ships as one.
// RL5: Clearing low-voltage enable needs high-voltage mode.
// RL6: Cleared enable refuses low-voltage entry.
// RL7: High voltage on master-clear always enters.
// RL8: Checksum adds code bytes and masked configs.
// RL9: ID bytes summed only when protected.
// RL10: Checksum keeps low sixteen bits only.
// RL11: Code and table-read protection act separately.
// RL12: Protected ID holds unprotected checksum nibbles.
// RL13: Config and ID always readable by programmer.
// RL14: Readout checksum sums values as read.
// RL15: Enable ignored when master-clear is off.
// RL16: ID contribution uses low nibble only.
// RL17: Accumulator clears at start of computation.
`timescale 1ns/1ps
`include "cpc_defs.svh"
module cpc_top
    import cpc_pkg::*;
#(
    parameter logic [10:0] PART_NUM = 11'h123,  // Arbitrary value
    parameter logic [4:0]  REVISION = 5'h01,    // Arbitrary value
    parameter int          NBLK     = `CPC_NBLK
)
(
    input  wire logic               clk_sys_i,
    input  wire logic               rstn_i,
    input  wire logic               hv_detect_i,
    input  wire logic               lv_entry_req_i,
    input  wire logic               master_clear_pin_enable_i,
    input  wire logic               prog_exit_i,
    input  wire cpc_cfg_wr_t        cfg_wr_i,
    input  wire logic [2:0]         cfg_rd_adr_i,
    output logic [7:0]              cfg_rd_dat_o,
    input  wire logic [2:0]         tbl_src_blk_i,
    input  wire logic [2:0]         tbl_dst_blk_i,
    input  wire logic               tbl_rd_req_i,
    output logic                    tbl_rd_allow_o,
    input  wire logic [2:0]         prg_rd_blk_i,
    input  wire logic               prg_rd_is_code_i,
    output logic                    prg_rd_allow_o,
    output cpc_mode_t               mode_o,
    input  wire cpc_sum_in_t        sum_i,
    output logic [`CPC_SUM_W-1:0]   checksum_o
);
    // Guard and protect vectors are laid out for exactly five blocks
    if (NBLK != `CPC_NBLK)
    begin
        $error("NBLK must equal five blocks");
    end

    cpc_mode_t   mode_r;
    cpc_mode_t   mode_nxt;
    logic [7:0]  trp_blk_r;
    logic [7:0]  trp_boot_r;
    logic        low_voltage_prog_enable_r;
    logic [7:0]  cp_r;
    logic [NBLK-1:0] guard;
    logic        lv_usable;
    logic        wr_trp_blk;
    logic        wr_trp_boot;
    logic        wr_cfg4l;
    logic        wr_cp;
    logic        in_prog;
    logic        any_cp;
    logic [7:0]  id_lo;
    logic [7:0]  id_hi;

    // Guard bits: 0 means the block is shielded from other blocks
    assign guard = {trp_boot_r[`CPC_TRP_BOOT_BIT], trp_blk_r[3:0]}; // [RL1]
    assign any_cp = ~&cp_r[NBLK-1:0];

    assign id_hi = PART_NUM[10:3];                            // [RL2]
    assign id_lo = {PART_NUM[2:0], REVISION};                 // [RL3]

    // The enable is only meaningful while master-clear is active
    assign lv_usable = low_voltage_prog_enable_r
                     & master_clear_pin_enable_i;             // [RL15]

    assign in_prog     = (mode_r != CPC_RUN);
    assign wr_trp_blk  = cfg_wr_i.we & in_prog
                       & (cfg_wr_i.adr == `CPC_ADR_TRP_BLK);
    assign wr_trp_boot = cfg_wr_i.we & in_prog
                       & (cfg_wr_i.adr == `CPC_ADR_TRP_BOOT);
    // Only high-voltage mode may touch the low-voltage enable
    assign wr_cfg4l    = cfg_wr_i.we & (mode_r == CPC_HV)
                       & (cfg_wr_i.adr == `CPC_ADR_CFG4L);    // [RL5]
    assign wr_cp       = cfg_wr_i.we & in_prog
                       & (cfg_wr_i.adr == `CPC_ADR_CP);

    always_comb
    begin
        mode_nxt = mode_r;
        unique case (mode_r)
            CPC_RUN:
            begin
                if (hv_detect_i)
                    mode_nxt = CPC_HV;                        // [RL7]
                else if (lv_entry_req_i && lv_usable)
                    mode_nxt = CPC_LV;                        // [RL6]
            end
            CPC_HV:
            begin
                if (prog_exit_i && !hv_detect_i)
                    mode_nxt = CPC_RUN;
            end
            CPC_LV:
            begin
                if (hv_detect_i)
                    mode_nxt = CPC_HV;                        // [RL7]
                else if (prog_exit_i)
                    mode_nxt = CPC_RUN;
            end
            default:
                mode_nxt = CPC_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            mode_r <= CPC_RUN;
        else
            mode_r <= mode_nxt;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            trp_blk_r                 <= `CPC_TRP_BLK_RST;
            trp_boot_r                <= `CPC_TRP_BOOT_RST;
            low_voltage_prog_enable_r <= `CPC_LV_EN_RST;      // [RL4]
            cp_r                      <= `CPC_CP_RST;
        end
        else
        begin
            if (wr_trp_blk)
                trp_blk_r <= cfg_wr_i.wdat & `CPC_TRP_BLK_MASK;
            if (wr_trp_boot)
                trp_boot_r <= cfg_wr_i.wdat & `CPC_TRP_BOOT_MASK;
            if (wr_cfg4l)
                low_voltage_prog_enable_r <= cfg_wr_i.wdat[`CPC_LV_EN_BIT];
            if (wr_cp)
                cp_r <= cfg_wr_i.wdat & `CPC_CP_RST;
        end
    end

    // Table reads from the same block are always allowed
    assign tbl_rd_allow_o = tbl_rd_req_i
        & ((tbl_src_blk_i == tbl_dst_blk_i)
           | ((tbl_dst_blk_i < 3'(NBLK)) & guard[tbl_dst_blk_i]));  // [RL1]

    // Code protection only gates the programmer; config stays visible
    assign prg_rd_allow_o = ~prg_rd_is_code_i                 // [RL13]
        | ((prg_rd_blk_i < 3'(NBLK)) & cp_r[prg_rd_blk_i]);  // [RL11]

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cfg_rd_dat_o <= 8'h00;
        else
        begin
            unique case (cfg_rd_adr_i)
                `CPC_ADR_TRP_BLK:  cfg_rd_dat_o <= trp_blk_r;
                `CPC_ADR_TRP_BOOT: cfg_rd_dat_o <= trp_boot_r;
                `CPC_ADR_ID_LO:    cfg_rd_dat_o <= id_lo;
                `CPC_ADR_ID_HI:    cfg_rd_dat_o <= id_hi;
                `CPC_ADR_CFG4L:    cfg_rd_dat_o <=
                    8'(low_voltage_prog_enable_r) << `CPC_LV_EN_BIT;
                `CPC_ADR_CP:       cfg_rd_dat_o <= cp_r;
                default:           cfg_rd_dat_o <= 8'h00;
            endcase
        end
    end

    assign mode_o = mode_r;

    // Protected-part ID nibbles are the programmer's business [RL12]
    cpc_sum u_sum
    (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .sum_i     (sum_i),
        .any_cp_i  (any_cp),
        .sum_o     (checksum_o)
    );

    sequence s_lv_req;
        (mode_r == CPC_RUN) && lv_entry_req_i && !hv_detect_i;
    endsequence

    property p_lv_refuse;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (s_lv_req and !lv_usable) |=> (mode_r == CPC_RUN);
    endproperty
    a_lv_refuse: assert property (p_lv_refuse) // [RL6]
        else $error("low-voltage entry not refused");

    property p_lv_enter;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (s_lv_req and lv_usable) |=> (mode_r == CPC_LV);
    endproperty
    a_lv_enter: assert property (p_lv_enter) // [RL15]
        else $error("low-voltage entry missed");

    property p_hv;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        hv_detect_i |=> (mode_r == CPC_HV);
    endproperty
    a_hv: assert property (p_hv) // [RL7]
        else $error("high-voltage entry missed");

    property p_lvp_hold;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (mode_r != CPC_HV) |=> $stable(low_voltage_prog_enable_r);
    endproperty
    a_lvp_hold: assert property (p_lvp_hold) // [RL5]
        else $error("enable changed outside high voltage");

    property p_tbl;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (tbl_rd_req_i && tbl_src_blk_i != tbl_dst_blk_i
         && tbl_dst_blk_i == 3'h0 && !trp_blk_r[0]) |-> !tbl_rd_allow_o;
    endproperty
    a_tbl: assert property (p_tbl) // [RL1]
        else $error("guarded block read from outside");

    property p_id;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (cfg_rd_adr_i == `CPC_ADR_ID_LO) |=>
            cfg_rd_dat_o == {PART_NUM[2:0], REVISION};
    endproperty
    a_id: assert property (p_id) // [RL3]
        else $error("lower ID register wrong");

    property p_cfg_vis;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !prg_rd_is_code_i |-> prg_rd_allow_o;
    endproperty
    a_cfg_vis: assert property (p_cfg_vis) // [RL13]
        else $error("config read blocked");
endmodule

// >>> hdl/cpc_defs.svh
/*
 Holds the offsets, field positions, reset values and masks of the
 code protection and identification block.
 Assumes inclusion by bare name from files that need the constants.
*/
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH
`define CPC_NBLK            5
`define CPC_BOOT_IDX        4
`define CPC_TRP_BOOT_BIT    6
`define CPC_LV_EN_BIT       2
`define CPC_LV_EN_RST       1'b1
`define CPC_TRP_BLK_RST     8'h0f
`define CPC_TRP_BOOT_RST    8'h40
`define CPC_TRP_BLK_MASK    8'h0f
`define CPC_TRP_BOOT_MASK   8'h40
`define CPC_ADR_TRP_BLK     3'h0
`define CPC_ADR_TRP_BOOT    3'h1
`define CPC_ADR_ID_LO       3'h2
`define CPC_ADR_ID_HI       3'h3
`define CPC_ADR_CFG4L       3'h4
`define CPC_ADR_CP          3'h5
`define CPC_CP_RST          8'h1f
`define CPC_SUM_W           16
`endif

// >>> hdl/cpc_pkg.sv
/*
 Types shared by the code protection block and its checksum unit.
 Assumes cpc_defs.svh is present on the include path.
*/
package cpc_pkg;
    typedef enum logic [1:0]
    {
        CPC_RUN  = 2'b00,
        CPC_HV   = 2'b01,
        CPC_LV   = 2'b10
    } cpc_mode_t;

    typedef struct packed
    {
        logic       we;
        logic [2:0] adr;
        logic [7:0] wdat;
    } cpc_cfg_wr_t;

    typedef struct packed
    {
        logic       vld;
        logic       clr;
        logic [7:0] dat;
        logic [7:0] mask;
        logic       is_id;
    } cpc_sum_in_t;
endpackage

// >>> hdl/cpc_sum.sv
/*
 Sixteen-bit checksum accumulator for program memory readout.
 Assumes one byte per valid cycle; clear starts a new computation.
*/
`timescale 1ns/1ps
`include "cpc_defs.svh"
module cpc_sum
    import cpc_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  rstn_i,
    input  wire cpc_sum_in_t           sum_i,
    input  wire logic                  any_cp_i,
    output logic [`CPC_SUM_W-1:0]      sum_o
);
    logic [`CPC_SUM_W-1:0] acc_r;
    logic [`CPC_SUM_W-1:0] acc_nxt;
    logic [7:0]            term;
    logic                  take;

    // ID bytes only count their low nibble, and only under protection
    assign take  = sum_i.vld & (~sum_i.is_id | any_cp_i);     // [RL9]
    assign term  = sum_i.is_id ? (sum_i.dat & 8'h0f)          // [RL16]
                               : (sum_i.dat & sum_i.mask);    // [RL8]
    // Carry beyond bit 15 is simply lost by the width
    assign acc_nxt = acc_r + {8'h00, term};                   // [RL10]
    assign sum_o = acc_r;

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            acc_r <= '0;
        else if (sum_i.clr)
            acc_r <= '0;                                      // [RL17]
        else if (take)
            acc_r <= acc_nxt;                                 // [RL14]
    end

    property p_id_excl;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (sum_i.vld && sum_i.is_id && !any_cp_i && !sum_i.clr)
            |=> $stable(acc_r);
    endproperty
    a_id_excl: assert property (p_id_excl) // [RL9]
        else $error("ID byte summed without protection");

    property p_clr;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        sum_i.clr |=> (acc_r == 16'h0000);
    endproperty
    a_clr: assert property (p_clr) // [RL17]
        else $error("accumulator not cleared");

    property p_add;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (sum_i.vld && !sum_i.is_id && !sum_i.clr) |=>
            acc_r == 16'($past(acc_r) + (($past(sum_i.dat)
                     & $past(sum_i.mask))));
    endproperty
    a_add: assert property (p_add) // [RL10]
        else $error("masked add wrong");
endmodule

// >>> test/cpc_prog_model.sv
/*
 Behavioural programmer: issues configuration writes and checksum bytes.
 Assumes the bench calls its tasks and keeps its own expected sum.
*/
`timescale 1ns/1ps
module cpc_prog_model
    import cpc_pkg::*;
(
    input  wire logic  clk_sys_i,
    output cpc_cfg_wr_t cfg_wr_o,
    output cpc_sum_in_t sum_o
);
    logic [15:0] exp = 16'h0000;

    initial
    begin
        cfg_wr_o = '{1'b0, 3'h7, 8'h5a};
        sum_o    = '0;
    end

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        cfg_wr_o <= '{1'b1, a, d};
        @(posedge clk_sys_i);
        // Idle lines show the inverse so stale data cannot pass
        cfg_wr_o <= '{1'b0, ~a, ~d};
    endtask

    task clr;
        @(posedge clk_sys_i);
        sum_o <= '{1'b0, 1'b1, 8'h00, 8'h00, 1'b0};
        exp = 16'h0000;
        @(posedge clk_sys_i);
        sum_o.clr <= 1'b0;
    endtask

    task add(input logic [7:0] d, m, input logic id, cp);
        @(posedge clk_sys_i);
        sum_o <= '{1'b1, 1'b0, d, m, id};
        if (!id)
            exp = exp + 16'(d & m);
        else if (cp)
            exp = exp + 16'(d & 8'h0f);
        @(posedge clk_sys_i);
        sum_o <= '{1'b0, 1'b0, ~d, ~m, id};
    endtask
endmodule

// >>> test/tb_code_protect_checksum.sv
/*
 Self-checking bench for the protection, identity and checksum block.
 Assumes cpc_top and the programmer model are compiled before it.
*/
`timescale 1ns/1ps
module tb_code_protect_checksum
    import cpc_pkg::*;
;
    localparam logic [10:0] PN = 11'h2a5;
    localparam logic [4:0]  RV = 5'h0b;
    logic        clk_sys_i = 0, rstn_i = 0;
    logic        hv = 0, lvr = 0, mce = 1, pex = 0, treq = 0, pc = 0;
    logic [2:0]  radr = 0, ts = 0, td = 0, pb = 0;
    logic [7:0]  rdat;
    logic        tal, pal;
    logic [15:0] csum;
    cpc_mode_t   mode;
    cpc_cfg_wr_t cwr;
    cpc_sum_in_t sin;
    int          n_errors = 0, cmp_count = 0, cyc = 0;
    logic [10:0] rw [6];

    always #12.5 clk_sys_i = ~clk_sys_i;

    cpc_top #(.PART_NUM(PN), .REVISION(RV)) u_cpc_top (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .hv_detect_i(hv),
        .lv_entry_req_i(lvr), .master_clear_pin_enable_i(mce),
        .prog_exit_i(pex), .cfg_wr_i(cwr), .cfg_rd_adr_i(radr),
        .cfg_rd_dat_o(rdat), .tbl_src_blk_i(ts), .tbl_dst_blk_i(td),
        .tbl_rd_req_i(treq), .tbl_rd_allow_o(tal), .prg_rd_blk_i(pb),
        .prg_rd_is_code_i(pc), .prg_rd_allow_o(pal), .mode_o(mode),
        .sum_i(sin), .checksum_o(csum));
    cpc_prog_model u_cpc_prog_model (.clk_sys_i(clk_sys_i),
        .cfg_wr_o(cwr), .sum_o(sin));

    task results;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            results();
        end
    end

    task chk(input logic [15:0] s, e, input string nm);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask

    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys_i) radr <= a;
        @(posedge clk_sys_i) #1 chk({8'h0, rdat}, {8'h0, e}, "cfg_rd");
    endtask

    task lv_en(input logic e);
        @(posedge clk_sys_i) radr <= 3'h4;
        @(posedge clk_sys_i) #1 chk({15'h0, rdat[2]}, {15'h0, e}, "lv_en");
    endtask

    task md(input logic h, l, x, c, input cpc_mode_t e);
        @(posedge clk_sys_i);
        hv  <= h;
        lvr <= l;
        pex <= x;
        mce <= c;
        @(posedge clk_sys_i);
        lvr <= 0;
        pex <= 0;
        #1 chk({14'h0, mode}, {14'h0, e}, "mode_o");
    endtask

    task tr(input logic [2:0] s, d, input logic e);
        @(posedge clk_sys_i);
        ts   <= s;
        td   <= d;
        treq <= 1;
        #1 chk({15'h0, tal}, {15'h0, e}, "tbl_rd_allow_o");
    endtask

    task pr(input logic [2:0] b, input logic c, e);
        @(posedge clk_sys_i);
        pb <= b;
        pc <= c;
        #1 chk({15'h0, pal}, {15'h0, e}, "prg_rd_allow_o");
    endtask

    task rows;
        foreach (rw[i])
            rd(rw[i][10:8], rw[i][7:0]);
        lv_en(1'b1);
    endtask

    initial
    begin
        rw = '{{3'h0, 8'h0f}, {3'h1, 8'h40}, {3'h2, PN[2:0], RV},
               {3'h3, PN[10:3]}, {3'h5, 8'h1f}, {3'h6, 8'h00}};
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1;
        rows();
        u_cpc_prog_model.wr(3'h0, 8'h00);
        rd(3'h0, 8'h0f);
        $display("reset and identity done");
        md(1, 0, 0, 1, CPC_HV);
        u_cpc_prog_model.wr(3'h0, 8'h0e);
        u_cpc_prog_model.wr(3'h1, 8'h00);
        u_cpc_prog_model.wr(3'h5, 8'h1e);
        tr(3'h1, 3'h0, 1'b0);
        tr(3'h0, 3'h0, 1'b1);
        tr(3'h0, 3'h4, 1'b0);
        tr(3'h3, 3'h2, 1'b1);
        pr(3'h0, 1'b1, 1'b0);
        pr(3'h1, 1'b1, 1'b1);
        pr(3'h0, 1'b0, 1'b1);
        $display("protection done");
        u_cpc_prog_model.clr();
        u_cpc_prog_model.add(8'hff, 8'hff, 1'b0, 1'b1);
        u_cpc_prog_model.add(8'h80, 8'h0f, 1'b0, 1'b1);
        u_cpc_prog_model.add(8'hab, 8'hff, 1'b1, 1'b1);
        #1 chk(csum, 16'h010a, "checksum_o");
        u_cpc_prog_model.wr(3'h5, 8'h1f);
        u_cpc_prog_model.clr();
        u_cpc_prog_model.add(8'hab, 8'hff, 1'b1, 1'b0);
        u_cpc_prog_model.add(8'h12, 8'hff, 1'b0, 1'b0);
        #1 chk(csum, u_cpc_prog_model.exp, "checksum_o");
        u_cpc_prog_model.clr();
        repeat (258) u_cpc_prog_model.add(8'hff, 8'hff, 1'b0, 1'b0);
        #1 chk(csum, 16'h00fe, "checksum_o");
        // ID bytes carry the nibbles 0,1,0,a with junk in the upper half
        u_cpc_prog_model.wr(3'h5, 8'h1e);
        u_cpc_prog_model.clr();
        u_cpc_prog_model.add(8'h20, 8'hff, 1'b0, 1'b1);
        u_cpc_prog_model.add(8'hf0, 8'hff, 1'b1, 1'b1);
        u_cpc_prog_model.add(8'he1, 8'hff, 1'b1, 1'b1);
        u_cpc_prog_model.add(8'hd0, 8'hff, 1'b1, 1'b1);
        u_cpc_prog_model.add(8'hca, 8'hff, 1'b1, 1'b1);
        #1 chk(csum, 16'h002b, "checksum_o");
        $display("checksum done");
        md(0, 0, 1, 1, CPC_RUN);
        md(0, 1, 0, 1, CPC_LV);
        u_cpc_prog_model.wr(3'h4, 8'h00);
        lv_en(1'b1);
        md(0, 0, 1, 1, CPC_RUN);
        md(0, 1, 0, 0, CPC_RUN);
        md(1, 0, 0, 1, CPC_HV);
        u_cpc_prog_model.wr(3'h4, 8'h00);
        lv_en(1'b0);
        md(0, 0, 1, 1, CPC_RUN);
        md(0, 1, 0, 1, CPC_RUN);
        md(1, 0, 0, 1, CPC_HV);
        $display("programming modes done");
        @(posedge clk_sys_i) rstn_i <= 0;
        @(posedge clk_sys_i) #1 chk({14'h0, mode}, 16'h0000, "mode_o");
        chk(csum, 16'h0000, "checksum_o");
        hv <= 0;
        @(posedge clk_sys_i) rstn_i <= 1;
        rows();
        $display("second reset done");
        results();
    end
endmodule
